// ===== hdl/mode_class_decode.sv
`timescale 1ns/10ps
module mode_class_decode (
  input wire logic [3:0] wave_gen_sel,
  output timer16_pkg::wave_class_e wclass,
  output logic [1:0] toggle_ok
);

  always_comb begin
    case (wave_gen_sel)
      timer16_pkg::MODE_NORMAL,
      timer16_pkg::MODE_CTC_CMPA,
      timer16_pkg::MODE_CTC_CAPT: wclass = timer16_pkg::CLASS_NON_PWM;
      timer16_pkg::MODE_FAST_8BIT,
      timer16_pkg::MODE_FAST_9BIT,
      timer16_pkg::MODE_FAST_10BIT,
      timer16_pkg::MODE_FAST_CAPT,
      timer16_pkg::MODE_FAST_CMPA: wclass = timer16_pkg::CLASS_FAST_PWM;
      timer16_pkg::MODE_RESERVED: wclass = timer16_pkg::CLASS_RESERVED;
      default: wclass = timer16_pkg::CLASS_DUAL_PWM;
    endcase
  end

  always_comb begin
    toggle_ok = 2'h0;
    case (wclass)
      timer16_pkg::CLASS_NON_PWM: toggle_ok = 2'h3;
      timer16_pkg::CLASS_FAST_PWM: toggle_ok[0] = (wave_gen_sel == timer16_pkg::MODE_FAST_CMPA);
      // dual toggle gate, values kept as printed
      timer16_pkg::CLASS_DUAL_PWM: toggle_ok[0] = (wave_gen_sel == timer16_pkg::MODE_PFC_CMPA) ||
                                                  (wave_gen_sel == timer16_pkg::MODE_FAST_CAPT);
      default: toggle_ok = 2'h0;
    endcase
  end

endmodule : mode_class_decode

// ===== hdl/timer16_compare_output_control.sv
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
module timer16_compare_output_control (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer_tick_en,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic override_a,
  output logic override_b
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] out_mode_a;
    logic [1:0] out_mode_b;
    logic [1:0] wave_gen_sel_lo;
    logic [1:0] wave_gen_sel_hi;
    logic [15:0] cmp_buf_a;
    logic [15:0] cmp_buf_b;
    logic [15:0] cmp_val_a;
    logic [15:0] cmp_val_b;
    logic [15:0] top_capture;
    logic [15:0] cnt;
    logic count_down;
    logic match_block;
    logic cmp_match_flag_a;
    logic cmp_match_flag_b;
    logic ovf_flag;
    logic force_cmp_a;
    logic force_cmp_b;
    logic ack;
    logic [31:0] dat;
  } top_state_s;

  top_state_s cur;
  top_state_s next_cur;

  logic [3:0] wave_gen_sel;
  timer16_pkg::wave_class_e wclass;
  logic [1:0] toggle_ok;
  logic [15:0] top_val;
  logic hit_top;
  logic hit_bottom;
  logic tick;
  logic [1:0] match_raw;
  logic [1:0] match_ev;
  logic top_ev;
  logic reload;
  logic bus_req;
  logic bus_wr;
  logic [1:0] out_mode_x [2];
  logic [1:0] force_x;
  logic [1:0] wave_x;
  logic [1:0] connect_x;

  // ----------------------------------------------------------------
  // mode select and top
  // ----------------------------------------------------------------
  // mode from both control registers
  assign wave_gen_sel = {cur.wave_gen_sel_hi, cur.wave_gen_sel_lo};

  mode_class_decode u_decode (
    .wave_gen_sel(wave_gen_sel),
    .wclass(wclass),
    .toggle_ok(toggle_ok)
  );

  always_comb begin
    case (wave_gen_sel)
      timer16_pkg::MODE_PC_8BIT,
      timer16_pkg::MODE_FAST_8BIT: top_val = timer16_pkg::TOP_8BIT;
      timer16_pkg::MODE_PC_9BIT,
      timer16_pkg::MODE_FAST_9BIT: top_val = timer16_pkg::TOP_9BIT;
      timer16_pkg::MODE_PC_10BIT,
      timer16_pkg::MODE_FAST_10BIT: top_val = timer16_pkg::TOP_10BIT;
      timer16_pkg::MODE_CTC_CMPA,
      timer16_pkg::MODE_PFC_CMPA,
      timer16_pkg::MODE_PC_CMPA,
      timer16_pkg::MODE_FAST_CMPA: top_val = cur.cmp_val_a;
      timer16_pkg::MODE_PFC_CAPT,
      timer16_pkg::MODE_PC_CAPT,
      timer16_pkg::MODE_CTC_CAPT,
      timer16_pkg::MODE_FAST_CAPT: top_val = cur.top_capture;
      default: top_val = timer16_pkg::CNT_MAX;
    endcase
  end

  // ----------------------------------------------------------------
  // compare events
  // ----------------------------------------------------------------
  // tick is a plain enable on sys_clk
  assign tick = timer_tick_en;
  assign hit_top = (cur.cnt == top_val);
  assign hit_bottom = (cur.cnt == timer16_pkg::CNT_BOTTOM);
  assign match_raw[0] = tick && !cur.match_block && (cur.cnt == cur.cmp_val_a);
  assign match_raw[1] = tick && !cur.match_block && (cur.cnt == cur.cmp_val_b);
  // in fast PWM only, match at top ignored when upper bit set
  assign match_ev[0] = match_raw[0] && !((wclass == timer16_pkg::CLASS_FAST_PWM) &&
                       (cur.cmp_val_a == top_val) && cur.out_mode_a[1]);
  assign match_ev[1] = match_raw[1] && !((wclass == timer16_pkg::CLASS_FAST_PWM) &&
                       (cur.cmp_val_b == top_val) && cur.out_mode_b[1]);
  assign top_ev = tick && (wclass == timer16_pkg::CLASS_FAST_PWM) && hit_top;

  always_comb begin
    reload = 1'b0;
    if ((wave_gen_sel == timer16_pkg::MODE_PFC_CAPT) ||
        (wave_gen_sel == timer16_pkg::MODE_PFC_CMPA)) begin
      reload = tick && cur.count_down && hit_bottom;
    end else if (wclass == timer16_pkg::CLASS_DUAL_PWM) begin
      reload = tick && !cur.count_down && hit_top;
    end else if (wclass == timer16_pkg::CLASS_FAST_PWM) begin
      reload = tick && hit_top;
    end
  end

  assign bus_req = wb_cyc_i && wb_stb_i && !cur.ack;
  assign bus_wr = bus_req && wb_we_i;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.ack = bus_req;
    next_cur.force_cmp_a = 1'b0;
    next_cur.force_cmp_b = 1'b0;
    if (tick) begin
      next_cur.match_block = 1'b0;
    end

    // counter sequence; reserved mode just counts like normal
    if (tick) begin
      case (wclass)
        timer16_pkg::CLASS_DUAL_PWM: begin
          if (!cur.count_down) begin
            if (hit_top) begin
              next_cur.count_down = 1'b1;
              next_cur.cnt = cur.cnt - 16'h0001;
            end else begin
              next_cur.cnt = cur.cnt + 16'h0001;
            end
          end else if (hit_bottom) begin
            next_cur.count_down = 1'b0;
            next_cur.cnt = cur.cnt + 16'h0001;
          end else begin
            next_cur.cnt = cur.cnt - 16'h0001;
          end
        end
        default: begin
          next_cur.count_down = 1'b0;
          next_cur.cnt = hit_top ? timer16_pkg::CNT_BOTTOM : cur.cnt + 16'h0001;
        end
      endcase
    end

    // active compare values
    if (wclass == timer16_pkg::CLASS_NON_PWM || wclass == timer16_pkg::CLASS_RESERVED) begin
      next_cur.cmp_val_a = cur.cmp_buf_a;
      next_cur.cmp_val_b = cur.cmp_buf_b;
    end else if (reload) begin
      next_cur.cmp_val_a = cur.cmp_buf_a;
      next_cur.cmp_val_b = cur.cmp_buf_b;
    end

    // register writes; flag clear is write-one
    if (bus_wr) begin
      if (wb_adr_i == timer16_pkg::ADDR_CONTROL_A) begin
        if (wb_sel_i[0]) begin
          next_cur.out_mode_a = wb_dat_i[timer16_pkg::OUT_MODE_A_LSB +: 2];
          next_cur.out_mode_b = wb_dat_i[timer16_pkg::OUT_MODE_B_LSB +: 2];
          next_cur.wave_gen_sel_lo = wb_dat_i[timer16_pkg::WAVE_SEL_LO_LSB +: 2];
          if (wclass == timer16_pkg::CLASS_NON_PWM) begin
            next_cur.force_cmp_a = wb_dat_i[timer16_pkg::FORCE_A_BIT];
            next_cur.force_cmp_b = wb_dat_i[timer16_pkg::FORCE_B_BIT];
          end
        end
      end else if (wb_adr_i == timer16_pkg::ADDR_CONTROL_B) begin
        if (wb_sel_i[0]) begin
          next_cur.wave_gen_sel_hi = wb_dat_i[timer16_pkg::WAVE_SEL_HI_LSB +: 2];
        end
      end else if (wb_adr_i == timer16_pkg::ADDR_CMP_VAL_A) begin
        if (wb_sel_i[0]) next_cur.cmp_buf_a[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) next_cur.cmp_buf_a[15:8] = wb_dat_i[15:8];
      end else if (wb_adr_i == timer16_pkg::ADDR_CMP_VAL_B) begin
        if (wb_sel_i[0]) next_cur.cmp_buf_b[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) next_cur.cmp_buf_b[15:8] = wb_dat_i[15:8];
      end else if (wb_adr_i == timer16_pkg::ADDR_TOP_CAPTURE) begin
        if (wb_sel_i[0]) next_cur.top_capture[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) next_cur.top_capture[15:8] = wb_dat_i[15:8];
      end else if (wb_adr_i == timer16_pkg::ADDR_COUNTER) begin
        // a written count masks the next tick's compare
        if (wb_sel_i[0]) next_cur.cnt[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) next_cur.cnt[15:8] = wb_dat_i[15:8];
        if (wb_sel_i[1:0] != 2'h0) next_cur.match_block = 1'b1;
      end else if (wb_adr_i == timer16_pkg::ADDR_STATUS) begin
        if (wb_sel_i[0]) begin
          if (wb_dat_i[timer16_pkg::FLAG_MATCH_A_BIT]) next_cur.cmp_match_flag_a = 1'b0;
          if (wb_dat_i[timer16_pkg::FLAG_MATCH_B_BIT]) next_cur.cmp_match_flag_b = 1'b0;
          if (wb_dat_i[timer16_pkg::FLAG_OVF_BIT]) next_cur.ovf_flag = 1'b0;
        end
      end
    end

    // only real matches set the match flags; set wins over clear
    if (match_raw[0]) next_cur.cmp_match_flag_a = 1'b1;
    if (match_raw[1]) next_cur.cmp_match_flag_b = 1'b1;
    if (tick && ((wclass == timer16_pkg::CLASS_FAST_PWM && hit_top) ||
        (wclass == timer16_pkg::CLASS_DUAL_PWM && cur.count_down && hit_bottom) ||
        (wclass != timer16_pkg::CLASS_FAST_PWM && wclass != timer16_pkg::CLASS_DUAL_PWM &&
         cur.cnt == timer16_pkg::CNT_MAX))) begin
      next_cur.ovf_flag = 1'b1;
    end

    // read data, unmapped reads zero
    next_cur.dat = timer16_pkg::BUS_DATA_RST;
    if (bus_req && !wb_we_i) begin
      if (wb_adr_i == timer16_pkg::ADDR_CONTROL_A) begin
        next_cur.dat[7:0] = {cur.out_mode_a, cur.out_mode_b, 2'h0, cur.wave_gen_sel_lo};
      end else if (wb_adr_i == timer16_pkg::ADDR_CONTROL_B) begin
        next_cur.dat[timer16_pkg::WAVE_SEL_HI_LSB +: 2] = cur.wave_gen_sel_hi;
      end else if (wb_adr_i == timer16_pkg::ADDR_CMP_VAL_A) begin
        next_cur.dat[15:0] = cur.cmp_buf_a;
      end else if (wb_adr_i == timer16_pkg::ADDR_CMP_VAL_B) begin
        next_cur.dat[15:0] = cur.cmp_buf_b;
      end else if (wb_adr_i == timer16_pkg::ADDR_TOP_CAPTURE) begin
        next_cur.dat[15:0] = cur.top_capture;
      end else if (wb_adr_i == timer16_pkg::ADDR_COUNTER) begin
        next_cur.dat[15:0] = cur.cnt;
      end else if (wb_adr_i == timer16_pkg::ADDR_STATUS) begin
        next_cur.dat[2:0] = {cur.ovf_flag, cur.cmp_match_flag_b, cur.cmp_match_flag_a};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // waveform channels
  // ----------------------------------------------------------------
  assign out_mode_x[0] = cur.out_mode_a;
  assign out_mode_x[1] = cur.out_mode_b;
  assign force_x = {cur.force_cmp_b, cur.force_cmp_a};

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    wave_evt_if evt ();
    assign evt.out_mode = out_mode_x[ch];
    assign evt.wclass = wclass;
    assign evt.toggle_ok = toggle_ok[ch];
    assign evt.match_ev = match_ev[ch];
    assign evt.top_ev = top_ev;
    assign evt.counting_up = !cur.count_down;
    assign evt.force_ev = force_x[ch];
    assign wave_x[ch] = evt.wave;
    assign connect_x[ch] = evt.connect;
    wave_unit u_wave (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .evt(evt.unit)
    );
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // override alone does not drive; port direction stays software's job
  assign wave_out_a = wave_x[0];
  assign wave_out_b = wave_x[1];
  assign override_a = connect_x[0];
  assign override_b = connect_x[1];
  assign wb_ack_o = cur.ack;
  assign wb_dat_o = cur.dat;

endmodule : timer16_compare_output_control

// ===== hdl/wave_unit.sv
`timescale 1ns/10ps
module wave_unit (
  input wire logic sys_clk,
  input wire logic rst_n,
  wave_evt_if.unit evt
);

  typedef struct packed {
    logic wave;
  } wave_state_s;

  wave_state_s cur;
  wave_state_s next_cur;

  assign evt.connect = (evt.out_mode != timer16_pkg::OUT_OFF) &&
                       !((evt.out_mode == timer16_pkg::OUT_TOGGLE) && !evt.toggle_ok);
  assign evt.wave = cur.wave;

  always_comb begin
    next_cur = cur;
    if (evt.force_ev) begin
      case (evt.out_mode)
        timer16_pkg::OUT_TOGGLE: next_cur.wave = ~cur.wave;
        timer16_pkg::OUT_CLEAR: next_cur.wave = 1'b0;
        timer16_pkg::OUT_SET: next_cur.wave = 1'b1;
        default: next_cur.wave = cur.wave;
      endcase
    end else begin
      case (evt.wclass)
        timer16_pkg::CLASS_NON_PWM: begin
          if (evt.match_ev) begin
            case (evt.out_mode)
              timer16_pkg::OUT_TOGGLE: next_cur.wave = ~cur.wave;
              timer16_pkg::OUT_CLEAR: next_cur.wave = 1'b0;
              timer16_pkg::OUT_SET: next_cur.wave = 1'b1;
              default: next_cur.wave = cur.wave;
            endcase
          end
        end
        timer16_pkg::CLASS_FAST_PWM: begin
          if (evt.match_ev) begin
            case (evt.out_mode)
              timer16_pkg::OUT_TOGGLE: next_cur.wave = evt.toggle_ok ? ~cur.wave : cur.wave;
              timer16_pkg::OUT_CLEAR: next_cur.wave = 1'b0;
              timer16_pkg::OUT_SET: next_cur.wave = 1'b1;
              default: next_cur.wave = cur.wave;
            endcase
          end
          if (evt.top_ev && evt.out_mode[1]) begin
            next_cur.wave = (evt.out_mode == timer16_pkg::OUT_CLEAR);
          end
        end
        timer16_pkg::CLASS_DUAL_PWM: begin
          if (evt.match_ev) begin
            case (evt.out_mode)
              timer16_pkg::OUT_TOGGLE: next_cur.wave = evt.toggle_ok ? ~cur.wave : cur.wave;
              timer16_pkg::OUT_CLEAR: next_cur.wave = ~evt.counting_up;
              timer16_pkg::OUT_SET: next_cur.wave = evt.counting_up;
              default: next_cur.wave = cur.wave;
            endcase
          end
        end
        default: next_cur.wave = cur.wave;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

endmodule : wave_unit

// ===== shared/timer16_pkg.sv
package timer16_pkg;

  // ----------------------------------------------------------------
  // waveform classes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLASS_NON_PWM,
    CLASS_FAST_PWM,
    CLASS_DUAL_PWM,
    CLASS_RESERVED
  } wave_class_e;

  // ----------------------------------------------------------------
  // register byte addresses (one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_A = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_B = 8'h04;
  localparam logic [7:0] ADDR_CMP_VAL_A = 8'h08;
  localparam logic [7:0] ADDR_CMP_VAL_B = 8'h0C;
  localparam logic [7:0] ADDR_TOP_CAPTURE = 8'h10;
  localparam logic [7:0] ADDR_COUNTER = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OUT_MODE_A_LSB = 6;
  localparam int OUT_MODE_B_LSB = 4;
  localparam int FORCE_A_BIT = 3;
  localparam int FORCE_B_BIT = 2;
  localparam int WAVE_SEL_LO_LSB = 0;
  localparam int WAVE_SEL_HI_LSB = 3;
  localparam int FLAG_MATCH_A_BIT = 0;
  localparam int FLAG_MATCH_B_BIT = 1;
  localparam int FLAG_OVF_BIT = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] OUT_MODE_RST = 2'h0;
  localparam logic [1:0] WAVE_SEL_PART_RST = 2'h0;
  localparam logic [15:0] WORD16_RST = 16'h0000;
  localparam logic [31:0] BUS_DATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // output mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] OUT_OFF = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_CLEAR = 2'h2;
  localparam logic [1:0] OUT_SET = 2'h3;

  // ----------------------------------------------------------------
  // waveform generation modes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PC_8BIT = 4'h1;
  localparam logic [3:0] MODE_PC_9BIT = 4'h2;
  localparam logic [3:0] MODE_PC_10BIT = 4'h3;
  localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
  localparam logic [3:0] MODE_FAST_8BIT = 4'h5;
  localparam logic [3:0] MODE_FAST_9BIT = 4'h6;
  localparam logic [3:0] MODE_FAST_10BIT = 4'h7;
  localparam logic [3:0] MODE_PFC_CAPT = 4'h8;
  localparam logic [3:0] MODE_PFC_CMPA = 4'h9;
  localparam logic [3:0] MODE_PC_CAPT = 4'hA;
  localparam logic [3:0] MODE_PC_CMPA = 4'hB;
  localparam logic [3:0] MODE_CTC_CAPT = 4'hC;
  localparam logic [3:0] MODE_RESERVED = 4'hD;
  localparam logic [3:0] MODE_FAST_CAPT = 4'hE;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hF;

  // ----------------------------------------------------------------
  // counter limits
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

endpackage : timer16_pkg

// ===== shared/wave_evt_if.sv
`timescale 1ns/10ps
interface wave_evt_if;
  logic [1:0] out_mode;
  timer16_pkg::wave_class_e wclass;
  logic toggle_ok;
  logic match_ev;
  logic top_ev;
  logic counting_up;
  logic force_ev;
  logic wave;
  logic connect;

  modport ctrl (
    output out_mode,
    output wclass,
    output toggle_ok,
    output match_ev,
    output top_ev,
    output counting_up,
    output force_ev,
    input wave,
    input connect
  );

  modport unit (
    input out_mode,
    input wclass,
    input toggle_ok,
    input match_ev,
    input top_ev,
    input counting_up,
    input force_ev,
    output wave,
    output connect
  );
endinterface : wave_evt_if

// ===== tb/pin_model.sv
`timescale 1ns/10ps
module pin_model (
  input wire logic wave,
  input wire logic override,
  input wire logic dir_out,
  input wire logic port_val,
  output logic pin
);
  // ------
  // pin mux
  // ------
  // override needs direction
  // released pin reads high through its pull-up
  assign pin = dir_out ? (override ? wave : port_val) : 1'b1;
endmodule : pin_model

// ===== tb/tcoc_checker.sv
`timescale 1ns/10ps
module tcoc_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic timer_tick_en,
  input wire logic wave_out_a,
  input wire logic wave_out_b,
  input wire logic override_a,
  input wire logic override_b
);
  // ------
  // checks
  // ------
  logic req;
  logic wa;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wa = req && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_ack_follows_req: assert property (req |=> wb_ack_o)
    else $error("ack late");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_force_read_zero: assert property (req && !wb_we_i && wb_adr_i == 8'h00
    |=> wb_dat_o[3:2] == 2'h0) else $error("force bits read nonzero");
  a_ctlb_layout: assert property (req && !wb_we_i && wb_adr_i == 8'h04
    |=> wb_dat_o[31:5] == 27'h0 && wb_dat_o[2:0] == 3'h0) else $error("control b bits");
  a_ovr_a_on: assert property (wa && wb_dat_i[7] |=> override_a)
    else $error("override a missing");
  a_ovr_b_on: assert property (wa && wb_dat_i[5] |=> override_b)
    else $error("override b missing");
  a_ovr_both_off: assert property (wa && wb_dat_i[7:4] == 4'h0
    |=> !override_a && !override_b) else $error("override stuck");
  a_wave_has_cause: assert property ($changed({wave_out_a, wave_out_b})
    |-> $past(timer_tick_en) || $past(wa, 2)) else $error("wave moved alone");
  a_reset_all_low: assert property ($rose(rst_n)
    |-> !wave_out_a && !wave_out_b && !override_a && !override_b) else $error("reset");
endmodule : tcoc_checker
bind timer16_compare_output_control tcoc_checker u_tcoc_checker (.*);

// ===== tb/timer16_compare_output_control_tb.sv
`timescale 1ns/10ps
module timer16_compare_output_control_tb;
  localparam logic [7:0] CA = timer16_pkg::ADDR_CONTROL_A;
  localparam logic [7:0] CB = timer16_pkg::ADDR_CONTROL_B;
  localparam logic [7:0] CM = timer16_pkg::ADDR_CMP_VAL_A;
  localparam logic [7:0] CN = timer16_pkg::ADDR_COUNTER;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0, dir_a = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
  logic ack, wva, wvb, oa, ob, pin_a;
  int failures = 0, comparisons = 0;
  initial forever #2 sys_clk = ~sys_clk;
  timer16_compare_output_control u_timer16_compare_output_control (.sys_clk(sys_clk),
    .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .timer_tick_en(tick), .wave_out_a(wva), .wave_out_b(wvb),
    .override_a(oa), .override_b(ob));
  pin_model u_pin_model (.wave(wva), .override(oa), .dir_out(dir_a), .port_val(1'b0),
    .pin(pin_a));
  // ------
  // helpers
  // ------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= d;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 20) begin
        failures++;
        finish_test();
      end
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  // ticks are single-cycle enables with idle gaps between them
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      tick <= 1'b1;
      @(posedge sys_clk);
      tick <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
  endtask : ticks
  // ------
  // scenarios
  // ------
  task automatic t_reset();
    bus(1'b0, CA, 32'h0);
    chk(rdat, 32'h0, "control a");
    bus(1'b0, CB, 32'h0);
    chk(rdat, 32'h0, "control b");
    bus(1'b0, 8'h20, 32'h0);
    chk(rdat, 32'h0, "unmapped");
  endtask : t_reset
  task automatic t_force();
    logic [7:0] c = 8'hE5;
    logic [3:0] e = 4'hA;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, CA, {24'h0, {2{c[7-2*i -: 2]}}, 4'hC});
      repeat (2) @(posedge sys_clk);
      chk(wva, e[3-i], "wave a");
      chk(wvb, e[3-i], "wave b");
      chk(pin_a, e[3-i], "pin a");
    end
    chk(oa, 1'b1, "override a");
    // released pin must not show the low waveform
    dir_a <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(pin_a, 1'b1, "pin released");
    dir_a <= 1'b1;
    bus(1'b0, CA, 32'h0);
    chk(rdat, 32'h0000_0050, "control a");
    bus(1'b0, 8'h18, 32'h0);
    chk(rdat, 32'h0, "status");
    bus(1'b0, CN, 32'h0);
    chk(rdat, 32'h0, "counter");
  endtask : t_force
  task automatic t_dual();
    bus(1'b1, CM, 32'h0000_00FE);
    bus(1'b1, CA, 32'h0000_00C1);
    bus(1'b1, CN, 32'h0000_00FD);
    ticks(2);
    chk(wva, 1'b1, "dual up");
    ticks(2);
    chk(wva, 1'b0, "dual down");
  endtask : t_dual
  task automatic t_fast();
    bus(1'b1, CA, 32'h0);
    bus(1'b1, CM, 32'h0000_0010);
    bus(1'b1, CB, 32'h0000_0008);
    bus(1'b1, CA, 32'h0000_00C1);
    bus(1'b1, CA, 32'h0000_00CD);
    repeat (3) @(posedge sys_clk);
    chk(wva, 1'b0, "force in pwm");
    bus(1'b1, CN, 32'h0000_000F);
    ticks(2);
    chk(wva, 1'b1, "fast match");
    bus(1'b1, CN, 32'h0000_00FE);
    ticks(2);
    chk(wva, 1'b0, "fast top");
  endtask : t_fast
  task automatic t_table();
    logic [19:0] md = 20'h5_F194;
    logic [4:0] ea = 5'h0B;
    logic [3:0] m;
    for (int i = 0; i < 5; i++) begin
      m = md[19-4*i -: 4];
      bus(1'b1, CB, {27'h0, m[3:2], 3'h0});
      bus(1'b1, CA, {24'h0, 6'h14, m[1:0]});
      chk(oa, ea[4-i], "toggle a");
      chk(ob, i == 4, "toggle b");
    end
    bus(1'b0, CB, 32'h0);
    chk(rdat, 32'h0000_0008, "control b");
  endtask : t_table
  // mode 8, top 4: compare b is 2 until bottom, then 3
  task automatic t_pfc();
    bus(1'b1, timer16_pkg::ADDR_CMP_VAL_B, 32'h0000_0002);
    bus(1'b1, timer16_pkg::ADDR_TOP_CAPTURE, 32'h0000_0004);
    bus(1'b1, CA, 32'h0000_0030);
    bus(1'b1, CB, 32'h0000_0010);
    bus(1'b1, timer16_pkg::ADDR_CMP_VAL_B, 32'h0000_0003);
    bus(1'b1, CN, 32'h0000_0001);
    ticks(2);
    chk(wvb, 1'b1, "dual b up");
    ticks(3);
    chk(wvb, 1'b1, "no reload at top");
    ticks(1);
    chk(wvb, 1'b0, "dual b down");
    ticks(4);
    chk(wvb, 1'b0, "old compare gone");
    ticks(1);
    chk(wvb, 1'b1, "reload at bottom");
  endtask : t_pfc
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_force();
    t_dual();
    t_fast();
    t_table();
    t_pfc();
    finish_test();
  end
endmodule : timer16_compare_output_control_tb
